// file: bles_map.svh
// Constants for byte-lane enable steering
`ifndef BLES_MAP_SVH
`define BLES_MAP_SVH
`define BLES_WIDTH_8 2'h0
`define BLES_WIDTH_16 2'h1
`define BLES_WIDTH_32 2'h2
`define BLES_LANES 4
`define BLES_STROBE_IDLE 4'hF
`define BLES_OE_RST 4'h0
`define BLES_ADDR_RST 2'h0
`endif

// file: bles_pkg.sv
// Types for byte-lane enable steering
`default_nettype none
package bles_pkg;
  typedef enum logic [1:0] {
    BLES_IDLE = 2'b00,
    BLES_ACCESS = 2'b01,
    BLES_EXT = 2'b11
  } bles_state_t;
endpackage : bles_pkg
`default_nettype wire

// file: bles_pin_if.sv
// Lane pin bundle between steering core and pin synchroniser
`timescale 1ns/1ns
`default_nettype none
interface bles_pin_if;
  logic [3:0] pin_in;
  logic [3:0] pin_sync;
  modport sync (input pin_in, output pin_sync);
  modport core (output pin_in, input pin_sync);
endinterface : bles_pin_if
`default_nettype wire

// file: bles_sync.sv
// Two-stage synchroniser for the four lane pins
`include "bles_map.svh"
`timescale 1ns/1ns
`default_nettype none
module bles_sync (
  input wire logic clk,
  input wire logic rst_n,
  bles_pin_if.sync pins
);
  logic [3:0] meta_r;
  logic [3:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < `BLES_LANES; i = i + 1) begin : g_lane
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= pins.pin_in[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign pins.pin_sync = sync_r;
endmodule : bles_sync
`default_nettype wire

// file: bles_steer.sv
// Byte-lane enable and low address pin steering for the external bus
`include "bles_map.svh"
`timescale 1ns/1ns
`default_nettype none
module bles_steer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus ownership and configuration
  input wire logic bus_master,
  input wire logic rw_lane_mode,
  input wire logic [1:0] region_width,
  // Access request from the bus interface
  input wire logic access_valid,
  input wire logic access_write,
  input wire logic [31:0] access_addr,
  input wire logic [3:0] access_bytes,
  // Lane pins, active-low strobes
  input wire logic [3:0] lane_pin_in,
  output logic [3:0] lane_pin_out,
  output logic [3:0] lane_pin_oe,
  // Decoded external master address bits
  output logic [1:0] ext_bank_sel,
  output logic [1:0] ext_byte_sel,
  output logic ext_page_cross
);
  bles_pin_if pins ();
  bles_pkg::bles_state_t state_r;
  bles_pkg::bles_state_t state_nxt;
  logic [3:0] strobe_r;
  logic [3:0] strobe_nxt;
  logic [3:0] oe_r;
  logic [1:0] bank_r;
  logic [1:0] byte_r;
  logic [1:0] byte_prev_r;
  logic cross_r;
  logic lanes_active;

  assign pins.pin_in = lane_pin_in;

  bles_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pins(pins)
  );

  // Reads only steer strobes in read/write mode
  assign lanes_active = access_valid && (access_write || rw_lane_mode);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bles_pkg::BLES_IDLE: begin
        if (!bus_master) state_nxt = bles_pkg::BLES_EXT;
        else if (access_valid) state_nxt = bles_pkg::BLES_ACCESS;
      end
      bles_pkg::BLES_ACCESS: begin
        if (!bus_master) state_nxt = bles_pkg::BLES_EXT;
        else if (!access_valid) state_nxt = bles_pkg::BLES_IDLE;
      end
      bles_pkg::BLES_EXT: begin
        if (bus_master) state_nxt = bles_pkg::BLES_IDLE;
      end
      default: state_nxt = bles_pkg::BLES_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_r <= bles_pkg::BLES_IDLE;
    else state_r <= state_nxt;
  end

  always_comb begin
    strobe_nxt = `BLES_STROBE_IDLE;
    case (region_width)
      `BLES_WIDTH_8: begin
        strobe_nxt[0] = !lanes_active;
        strobe_nxt[1] = 1'b1;
        strobe_nxt[2] = access_addr[1];
        strobe_nxt[3] = access_addr[0];
      end
      `BLES_WIDTH_16: begin
        strobe_nxt[0] = !(lanes_active && access_bytes[0]);
        strobe_nxt[1] = !(lanes_active && access_bytes[1]);
        strobe_nxt[2] = access_addr[1];
        strobe_nxt[3] = access_addr[0];
      end
      `BLES_WIDTH_32: begin
        strobe_nxt = ~(access_bytes & {4{lanes_active}});
      end
      default: strobe_nxt = `BLES_STROBE_IDLE;
    endcase
  end

  // Strobes register once per cycle so pins stay glitch-free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) strobe_r <= `BLES_STROBE_IDLE;
    else if (!bus_master) strobe_r <= `BLES_STROBE_IDLE;
    else strobe_r <= strobe_nxt;
  end

  // Drivers drop the same cycle bus ownership is lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oe_r <= `BLES_OE_RST;
    else oe_r <= {4{bus_master}};
  end

  assign lane_pin_out = strobe_r;
  assign lane_pin_oe = oe_r & {4{bus_master}};

  // External master address capture from synchronised pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_r <= `BLES_ADDR_RST;
      byte_r <= `BLES_ADDR_RST;
      byte_prev_r <= `BLES_ADDR_RST;
      cross_r <= 1'b0;
    end else if (state_r == bles_pkg::BLES_EXT) begin
      bank_r <= pins.pin_sync[1:0];
      byte_r <= {pins.pin_sync[2], pins.pin_sync[3]};
      byte_prev_r <= byte_r;
      // Wrap of A30:31 from 3 back to 0 marks a word boundary step
      cross_r <= (byte_r == 2'h3) && ({pins.pin_sync[2], pins.pin_sync[3]} == 2'h0);
    end else begin
      cross_r <= 1'b0;
    end
  end

  assign ext_bank_sel = bank_r;
  assign ext_byte_sel = byte_r;
  assign ext_page_cross = cross_r;
endmodule : bles_steer
`default_nettype wire

// file: bles_steer_assertions.sv
// Lane steering checker
`timescale 1ns/1ns
`default_nettype none
module bles_chk (
  // Clock, reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs
  input wire logic bus_master,
  input wire logic rw_lane_mode,
  input wire logic [1:0] region_width,
  input wire logic access_valid,
  input wire logic access_write,
  input wire logic [3:0] access_bytes,
  input wire logic [31:0] access_addr,
  input wire logic [3:0] lane_pin_in,
  // Outputs
  input wire logic [3:0] lane_pin_out,
  input wire logic [3:0] lane_pin_oe,
  input wire logic [1:0] ext_bank_sel,
  input wire logic [1:0] ext_byte_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire go = bus_master && access_valid;
  wire w32 = go && region_width == 2'h2;
  a_oe_off: assert property (!bus_master |-> lane_pin_oe == 4'h0)
    else $error("oe");
  a_out_park: assert property ($past(!bus_master) && !bus_master |-> &lane_pin_out)
    else $error("park");
  a_lanes_32: assert property (w32 && (access_write || rw_lane_mode) |=>
    lane_pin_out == ~$past(access_bytes)) else $error("l32");
  a_read_quiet: assert property (w32 && !access_write && !rw_lane_mode |=>
    &lane_pin_out) else $error("rd");
  a_lanes_16: assert property (go && access_write && region_width == 2'h1 |=>
    lane_pin_out[1:0] == ~$past(access_bytes[1:0])) else $error("l16");
  a_lane_8: assert property (go && access_write && region_width == 2'h0 && access_bytes == 4'h1 |=>
    !lane_pin_out[0]) else $error("l8");
  a_bank_sel: assert property ((!bus_master && $stable(lane_pin_in)) [*5] |->
    ext_bank_sel == lane_pin_in[1:0]) else $error("bank");
  a_byte_sel: assert property ((!bus_master && $stable(lane_pin_in)) [*5] |->
    ext_byte_sel == {lane_pin_in[2], lane_pin_in[3]}) else $error("byte");
  a_addr_lanes: assert property (bus_master && !region_width[1] |=>
    lane_pin_out[3:2] == {$past(access_addr[0]), $past(access_addr[1])}) else $error("addr");
endmodule : bles_chk
bind bles_steer bles_chk i_bles_chk (.clk, .rst_n, .bus_master, .rw_lane_mode, .region_width,
  .access_valid, .access_write, .access_bytes, .access_addr, .lane_pin_in, .lane_pin_out,
  .lane_pin_oe,
  .ext_bank_sel, .ext_byte_sel);
`default_nettype wire

// file: bles_xm.sv
// External bus master model for the lane pins
`timescale 1ns/1ns
`default_nettype none
module bles_xm (
  // Ownership and address to present
  input wire logic bus_master,
  input wire logic [3:0] addr,
  // Lane pin drive
  output logic [3:0] pins
);
  // Inverted while released so a stale address never reads as fresh
  assign pins = bus_master ? ~addr : addr;
endmodule : bles_xm
`default_nettype wire

// file: tb_bles_steer.sv
// Lane steering testbench
`timescale 1ns/1ns
`default_nettype none
module tb_bles_steer;
  logic clk = 0, rst_n = 0, bus_master = 0, rw_lane_mode = 0;
  logic access_valid = 0, access_write = 0, pc;
  logic [1:0] region_width = 2'h2, bank, bsel;
  logic [31:0] addr = 32'h0;
  logic [3:0] access_bytes = 4'h0, xa = 4'hC, xp, lane, out, oe;
  int err_total = 0, checks = 0;
  always #25 clk = ~clk;
  assign lane = (oe & out) | (~oe & xp);
  bles_steer i_bles_steer (.clk, .rst_n, .bus_master, .rw_lane_mode, .region_width,
    .access_valid, .access_write, .access_addr(addr), .access_bytes, .lane_pin_in(lane),
    .lane_pin_out(out), .lane_pin_oe(oe), .ext_bank_sel(bank), .ext_byte_sel(bsel),
    .ext_page_cross(pc));
  bles_xm i_bles_xm (.bus_master, .addr(xa), .pins(xp));
  task automatic chk(string n, logic [3:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic acc(logic w, m, logic [1:0] r, logic [3:0] b);
    access_write = w;
    rw_lane_mode = m;
    region_width = r;
    access_bytes = b;
    @(posedge clk);
    #5;
  endtask : acc
  task automatic t_bus;
    bus_master = 1;
    access_valid = 1;
    for (int i = 1; i < 16; i++) begin
      acc(1, 0, 2'h2, i[3:0]);
      chk("wr32", ~i[3:0], out);
    end
    chk("oe", 4'hF, oe);
    acc(0, 0, 2'h2, 4'h5);
    chk("rd", 4'hF, out);
    acc(0, 1, 2'h2, 4'h5);
    chk("rdm", 4'hA, out);
    acc(1, 0, 2'h1, 4'h1);
    chk("wr16", 4'h2, {2'h0, out[1:0]});
    acc(1, 0, 2'h0, 4'h1);
    chk("wr8", 4'h0, {3'h0, out[0]});
    addr = 32'h1;
    acc(1, 0, 2'h0, 4'h1);
    chk("wr8a", 4'hA, out);
    addr = 32'h2;
    acc(1, 0, 2'h1, 4'h2);
    chk("wr16a", 4'h5, out);
    addr = 32'h0;
    acc(1, 0, 2'h3, 4'hF);
    chk("w3idle", 4'hF, out);
    $display("t_bus done");
  endtask : t_bus
  task automatic t_ext;
    int n = 0;
    bus_master = 0;
    access_valid = 0;
    repeat (6) @(posedge clk);
    #5;
    chk("oe0", 4'h0, oe);
    chk("park", 4'hF, out);
    chk("sel", 4'h3, {bank, bsel});
    // Byte select wraps 3 to 0 here, so exactly one crossing pulse
    xa = 4'h1;
    repeat (6) begin
      @(posedge clk);
      #5;
      n += pc;
    end
    chk("sel2", 4'h4, {bank, bsel});
    chk("cross", 4'h1, n[3:0]);
    $display("t_ext done");
  endtask : t_ext
  task automatic give_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #10000;
    err_total++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge clk);
    #5;
    rst_n = 1;
    t_bus;
    t_ext;
    give_verdict;
  end
endmodule : tb_bles_steer
`default_nettype wire
